// ===== vdtc_pkg.sv
package vdtc_pkg;

  // descriptor layout and data unit sizes
  localparam logic [1:0]  MODE_NORMAL = 2'h0;
  localparam logic [1:0]  MODE_REPEAT = 2'h1;
  localparam logic [1:0]  MODE_BLOCK  = 2'h2;
  localparam logic [1:0]  SIZE_8      = 2'h0;
  localparam logic [1:0]  SIZE_16     = 2'h1;
  localparam logic [1:0]  SIZE_32     = 2'h2;
  localparam logic [1:0]  AM_INC      = 2'h2;  // bit 1 clear means fixed address
  localparam logic [1:0]  AM_DEC      = 2'h3;
  localparam int unsigned SHORT_AW    = 24;    // address width of the short layout
  localparam logic [1:0]  FULL_LAST   = 2'h3;  // full layout: four words
  localparam logic [1:0]  SHORT_LAST  = 2'h2;  // short layout: three words
  localparam logic [7:0]  CNT_ONE     = 8'h01;
  localparam logic [15:0] CRA_ONE     = 16'h0001;
  localparam logic [15:0] CRB_ONE     = 16'h0001;
  localparam logic [8:0]  BLOCK_MAX   = 9'h100;  // a count of zero means 256 units

  // register spaces that may never be an endpoint
  localparam logic [31:0] DMA_CONTROLLER_REG_LO = 32'h0008_2000;
  localparam logic [31:0] DMA_CONTROLLER_REG_HI = 32'h0008_23FF;
  localparam logic [31:0] SELF_REG_LO = 32'h0008_2400;
  localparam logic [31:0] SELF_REG_HI = 32'h0008_24FF;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] size;
    logic [1:0] sam;
    logic [1:0] rsv;
  } vdtc_mra_s;

  typedef struct packed {
    logic       chne;    // chain enable
    logic       chns;    // chain only when the counter runs out
    logic       disel;   // cpu interrupt after every unit
    logic       dts;     // 1: source is the repeat/block side
    logic [1:0] dam;
    logic       wbskip;  // skip writing the descriptor back
    logic       rsv;
  } vdtc_mrb_s;

  typedef struct packed {
    vdtc_mra_s   mra;
    vdtc_mrb_s   mrb;
    logic [31:0] sar;
    logic [31:0] dar;
    logic [15:0] cra;
    logic [15:0] crb;
  } vdtc_desc_s;

  typedef struct packed {
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } vdtc_mreq_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_VEC  = 3'h1,
    ST_DESC = 3'h2,
    ST_RD   = 3'h3,
    ST_WR   = 3'h4,
    ST_WB   = 3'h5
  } vdtc_state_e;

  // descriptor word i in memory order
  function automatic logic [31:0] vdtc_desc_word(vdtc_desc_s d, logic sh, logic [1:0] i);
    case (i)
      2'h0:    vdtc_desc_word = sh ? {d.mra, d.sar[SHORT_AW-1:0]} : {d.mra, d.mrb, 16'h0000};
      2'h1:    vdtc_desc_word = sh ? {d.mrb, d.dar[SHORT_AW-1:0]} : d.sar;
      2'h2:    vdtc_desc_word = sh ? {d.cra, d.crb} : d.dar;
      default: vdtc_desc_word = {d.cra, d.crb};
    endcase
  endfunction

  // merge descriptor word i into a held descriptor
  function automatic vdtc_desc_s vdtc_desc_load(vdtc_desc_s d, logic sh, logic [1:0] i,
                                                logic [31:0] w);
    vdtc_desc_s r;
    r = d;
    case (i)
      2'h0: begin
        r.mra = w[31:24];
        if (sh) begin
          r.sar = {8'h00, w[SHORT_AW-1:0]};
        end else begin
          r.mrb = w[23:16];
        end
      end
      2'h1: begin
        if (sh) begin
          r.mrb = w[31:24];
          r.dar = {8'h00, w[SHORT_AW-1:0]};
        end else begin
          r.sar = w;
        end
      end
      2'h2: begin
        if (sh) begin
          r.cra = w[31:16];
          r.crb = w[15:0];
        end else begin
          r.dar = w;
        end
      end
      default: begin
        r.cra = w[31:16];
        r.crb = w[15:0];
      end
    endcase
    return r;
  endfunction

endpackage

// ===== vdtc_addr_step.sv
`timescale 1ns/1ps
module vdtc_addr_step
  import vdtc_pkg::*;
(
  input  wire logic [31:0] addr,
  input  wire logic [1:0]  amode,
  input  wire logic [1:0]  size,
  input  wire logic        restore,
  input  wire logic [7:0]  reload,
  output logic      [31:0] addr_nxt,
  output logic             forbidden
);

  logic [31:0] step;
  logic [31:0] off;
  logic [31:0] stepped;
  logic [8:0]  units;

  // step one unit, and on restore walk back over the whole repeat/block area
  always_comb begin
    step    = 32'h0000_0001 << size;
    units   = (reload == 8'h00) ? BLOCK_MAX : {1'b0, reload};
    off     = {23'h000000, units} << size;
    stepped = addr;
    if (amode == AM_INC) begin
      stepped = addr + step;
    end else if (amode == AM_DEC) begin
      stepped = addr - step;
    end
    addr_nxt = stepped;
    if (restore && amode == AM_INC) begin
      addr_nxt = stepped - off;
    end else if (restore && amode == AM_DEC) begin
      addr_nxt = stepped + off;
    end
  end

  // own and dma controller register spaces are never endpoints
  assign forbidden = (addr >= DMA_CONTROLLER_REG_LO && addr <= DMA_CONTROLLER_REG_HI) ||
                     (addr >= SELF_REG_LO && addr <= SELF_REG_HI);

endmodule

// ===== vdtc_core.sv
`timescale 1ns/1ps
module vdtc_core
  import vdtc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        module_start_control,
  input  wire logic        descriptor_address_mode,
  input  wire logic [31:0] vector_table_base,
  input  wire logic        read_skip_enable,
  input  wire logic        act_req,
  input  wire logic [7:0]  act_vector,
  input  wire logic        source_activation_enable,
  output logic             act_ack,
  output logic             mem_req,
  output vdtc_mreq_s       mem_o,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic             cpu_irq,
  output logic      [7:0]  cpu_irq_vector,
  output logic             xfer_error,
  output logic             transfer_active,
  output logic      [7:0]  active_vector_number
);

  vdtc_state_e st_r, st_nxt;
  vdtc_desc_s  d_r, d_nxt;
  logic [31:0] daddr_r, daddr_nxt;
  logic [7:0]  vec_r, vec_nxt;
  logic [1:0]  wcnt_r, wcnt_nxt;
  logic [31:0] data_r, data_nxt;
  logic        chain_r, chain_nxt;
  logic        chained_r, chained_nxt;
  logic        last_ok_r, last_ok_nxt;
  logic        irq_r, irq_nxt;
  logic [7:0]  irqv_r, irqv_nxt;
  logic        err_r, err_nxt;

  logic [1:0]  last_w;
  logic [31:0] size_mask;
  logic [31:0] src_nxt;
  logic [31:0] dst_nxt;
  logic        src_bad;
  logic        dst_bad;
  logic        wrap;
  logic        exh;
  logic        src_rst;
  logic        dst_rst;

  assign last_w = descriptor_address_mode ? SHORT_LAST : FULL_LAST;

  always_comb begin
    case (d_r.mra.size)
      SIZE_8:  size_mask = 32'h0000_00FF;
      SIZE_16: size_mask = 32'h0000_FFFF;
      default: size_mask = 32'hFFFF_FFFF;
    endcase
  end

  // repeat and block counter wrap with area restore
  always_comb begin
    wrap    = (d_r.mra.mode != MODE_NORMAL) && (d_r.cra[7:0] == CNT_ONE);
    src_rst = wrap && d_r.mrb.dts;
    dst_rst = wrap && !d_r.mrb.dts;
    exh     = 1'b0;
    if (d_r.mra.mode == MODE_NORMAL) begin
      exh = (d_r.cra == CRA_ONE);
    end else if (d_r.mra.mode == MODE_BLOCK) begin
      exh = wrap && (d_r.crb == CRB_ONE);
    end
  end

  // address steppers for both endpoints
  vdtc_addr_step u_src_step (
    .addr      (d_r.sar),
    .amode     (d_r.mra.sam),
    .size      (d_r.mra.size),
    .restore   (src_rst),
    .reload    (d_r.cra[15:8]),
    .addr_nxt  (src_nxt),
    .forbidden (src_bad)
  );

  vdtc_addr_step u_dst_step (
    .addr      (d_r.dar),
    .amode     (d_r.mrb.dam),
    .size      (d_r.mra.size),
    .restore   (dst_rst),
    .reload    (d_r.cra[15:8]),
    .addr_nxt  (dst_nxt),
    .forbidden (dst_bad)
  );

  // memory request drive from held state
  always_comb begin
    mem_req = 1'b0;
    mem_o   = '0;
    mem_o.size = SIZE_32;
    case (st_r)
      ST_VEC: begin
        mem_req    = 1'b1;
        mem_o.addr = vector_table_base + {22'h000000, vec_r, 2'b00};
      end
      ST_DESC: begin
        mem_req    = 1'b1;
        mem_o.addr = daddr_r + {28'h0000000, wcnt_r, 2'b00};
      end
      ST_RD: begin
        mem_req    = !src_bad;
        mem_o.size = d_r.mra.size;
        mem_o.addr = d_r.sar;
      end
      ST_WR: begin
        mem_req     = !dst_bad;
        mem_o.we    = 1'b1;
        mem_o.size  = d_r.mra.size;
        mem_o.addr  = d_r.dar;
        mem_o.wdata = data_r;
      end
      ST_WB: begin
        mem_req     = !d_r.mrb.wbskip;
        mem_o.we    = 1'b1;
        mem_o.addr  = daddr_r + {28'h0000000, wcnt_r, 2'b00};
        mem_o.wdata = vdtc_desc_word(d_r, descriptor_address_mode, wcnt_r);
      end
      default: begin
        mem_req = 1'b0;
      end
    endcase
  end

  // sequencer next state
  always_comb begin
    st_nxt      = st_r;
    d_nxt       = d_r;
    daddr_nxt   = daddr_r;
    vec_nxt     = vec_r;
    wcnt_nxt    = wcnt_r;
    data_nxt    = data_r;
    chain_nxt   = chain_r;
    chained_nxt = chained_r;
    last_ok_nxt = last_ok_r;
    irq_nxt     = 1'b0;
    irqv_nxt    = irqv_r;
    err_nxt     = 1'b0;
    act_ack     = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (act_req) begin
          act_ack = 1'b1;
          // stopped module or disabled source goes to the cpu
          if (!source_activation_enable || !module_start_control) begin
            irq_nxt  = 1'b1;
            irqv_nxt = act_vector;
          end else begin
            vec_nxt     = act_vector;
            wcnt_nxt    = 2'h0;
            chained_nxt = 1'b0;
            if (read_skip_enable && last_ok_r && act_vector == vec_r) begin
              st_nxt = ST_RD;
            end else begin
              st_nxt = ST_VEC;
            end
          end
        end
      end
      ST_VEC: begin
        if (mem_ack) begin
          daddr_nxt = mem_rdata;
          st_nxt    = ST_DESC;
        end
      end
      ST_DESC: begin
        if (mem_ack) begin
          d_nxt = vdtc_desc_load(d_r, descriptor_address_mode, wcnt_r, mem_rdata);
          if (wcnt_r == last_w) begin
            wcnt_nxt = 2'h0;
            st_nxt   = ST_RD;
          end else begin
            wcnt_nxt = wcnt_r + 2'h1;
          end
        end
      end
      ST_RD: begin
        if (src_bad) begin
          err_nxt     = 1'b1;
          last_ok_nxt = 1'b0;
          st_nxt      = ST_IDLE;
        end else if (mem_ack) begin
          data_nxt = mem_rdata & size_mask;
          st_nxt   = ST_WR;
        end
      end
      ST_WR: begin
        if (dst_bad) begin
          err_nxt     = 1'b1;
          last_ok_nxt = 1'b0;
          st_nxt      = ST_IDLE;
        end else if (mem_ack) begin
          d_nxt.sar = src_nxt;
          d_nxt.dar = dst_nxt;
          if (d_r.mra.mode == MODE_NORMAL) begin
            d_nxt.cra = d_r.cra - CRA_ONE;
          end else begin
            d_nxt.cra[7:0] = wrap ? d_r.cra[15:8] : d_r.cra[7:0] - CNT_ONE;
          end
          if (d_r.mra.mode == MODE_BLOCK && wrap) begin
            d_nxt.crb = d_r.crb - CRB_ONE;
          end
          irq_nxt  = d_r.mrb.disel || exh;
          irqv_nxt = vec_r;
          // stay inside the block until it is complete
          if (d_r.mra.mode == MODE_BLOCK && !wrap) begin
            st_nxt = ST_RD;
          end else begin
            chain_nxt = d_r.mrb.chne && (!d_r.mrb.chns || exh);
            wcnt_nxt  = 2'h0;
            st_nxt    = ST_WB;
          end
        end
      end
      ST_WB: begin
        // write back, then chain or release
        if (d_r.mrb.wbskip || (mem_ack && wcnt_r == last_w)) begin
          wcnt_nxt = 2'h0;
          if (chain_r) begin
            daddr_nxt   = daddr_r + {28'h0000000, last_w, 2'b00} + 32'h0000_0004;
            chain_nxt   = 1'b0;
            chained_nxt = 1'b1;
            st_nxt      = ST_DESC;
          end else begin
            last_ok_nxt = !chained_r;
            st_nxt      = ST_IDLE;
          end
        end else if (mem_ack) begin
          wcnt_nxt = wcnt_r + 2'h1;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r      <= ST_IDLE;
      d_r       <= '0;
      daddr_r   <= 32'h0000_0000;
      vec_r     <= 8'h00;
      wcnt_r    <= 2'h0;
      data_r    <= 32'h0000_0000;
      chain_r   <= 1'b0;
      chained_r <= 1'b0;
      last_ok_r <= 1'b0;
      irq_r     <= 1'b0;
      irqv_r    <= 8'h00;
      err_r     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      d_r       <= d_nxt;
      daddr_r   <= daddr_nxt;
      vec_r     <= vec_nxt;
      wcnt_r    <= wcnt_nxt;
      data_r    <= data_nxt;
      chain_r   <= chain_nxt;
      chained_r <= chained_nxt;
      last_ok_r <= last_ok_nxt;
      irq_r     <= irq_nxt;
      irqv_r    <= irqv_nxt;
      err_r     <= err_nxt;
    end
  end

  assign transfer_active      = (st_r != ST_IDLE);
  assign active_vector_number = vec_r;
  assign cpu_irq              = irq_r;
  assign cpu_irq_vector       = irqv_r;
  assign xfer_error           = err_r;

  vec_fetch_a: assert property (@(posedge clock) disable iff (srst)
    st_r == ST_VEC && mem_req |->
      mem_o.addr == vector_table_base + {22'h000000, vec_r, 2'b00} && !mem_o.we)
    else $error("vector fetch address wrong");

  stop_holds_a: assert property (@(posedge clock) disable iff (srst)
    st_r == ST_IDLE && act_req && !module_start_control |=> st_r == ST_IDLE ##0 cpu_irq)
    else $error("stopped module started a transfer");

  no_forbid_a: assert property (@(posedge clock) disable iff (srst)
    mem_req && (st_r == ST_RD || st_r == ST_WR) |->
      !(mem_o.addr >= DMA_CONTROLLER_REG_LO && mem_o.addr <= DMA_CONTROLLER_REG_HI) &&
      !(mem_o.addr >= SELF_REG_LO && mem_o.addr <= SELF_REG_HI))
    else $error("forbidden endpoint accessed");

  unit_size_a: assert property (@(posedge clock) disable iff (srst)
    mem_req && (st_r == ST_RD || st_r == ST_WR) |-> mem_o.size == d_r.mra.size)
    else $error("unit size differs from descriptor");

  unit_irq_a: assert property (@(posedge clock) disable iff (srst)
    st_r == ST_WR && mem_ack && !dst_bad && d_r.mrb.disel |=>
      cpu_irq && cpu_irq_vector == $past(vec_r))
    else $error("missing per-unit interrupt");

  end_irq_a: assert property (@(posedge clock) disable iff (srst)
    st_r == ST_WR && mem_ack && !dst_bad && d_r.mra.mode == MODE_NORMAL &&
      d_r.cra == CRA_ONE |=> cpu_irq ##0 d_r.cra == 16'h0000)
    else $error("missing counter-end interrupt");

  block_loop_a: assert property (@(posedge clock) disable iff (srst)
    st_r == ST_WR && mem_ack && !dst_bad && d_r.mra.mode == MODE_BLOCK && !wrap |=>
      st_r == ST_RD && d_r.crb == $past(d_r.crb))
    else $error("block ended early");

  repeat_reload_a: assert property (@(posedge clock) disable iff (srst)
    st_r == ST_WR && mem_ack && !dst_bad && d_r.mra.mode == MODE_REPEAT && wrap |=>
      d_r.cra[7:0] == $past(d_r.cra[15:8]))
    else $error("repeat counter not reloaded");

  wb_write_a: assert property (@(posedge clock) disable iff (srst)
    st_r == ST_WB && !d_r.mrb.wbskip |->
      mem_req && mem_o.we && mem_o.addr == daddr_r + {28'h0000000, wcnt_r, 2'b00})
    else $error("write-back access wrong");

  busy_flag_a: assert property (@(posedge clock) disable iff (srst)
    act_ack && module_start_control && source_activation_enable |=>
      transfer_active && active_vector_number == $past(act_vector))
    else $error("busy status or vector wrong");

endmodule

// ===== vdtc_mem_model.sv
`timescale 1ns/1ps
// memory side of the system bus, one access at a time with a variable wait
module vdtc_mem_model
  import vdtc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        mem_req,
  input  wire vdtc_mreq_s  mem_o,
  input  wire logic [1:0]  wait_cycles,
  output logic             mem_ack = 1'b0,
  output logic      [31:0] mem_rdata = 32'h0000_0000
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] key;
  logic [31:0] msk;
  logic [4:0]  sh;
  logic [1:0]  cnt = 2'h0;

  // answer after the wait; read data is scrambled outside the ack cycle
  always @(posedge clock) begin
    key = {mem_o.addr[31:2], 2'h0};
    sh = {mem_o.addr[1:0], 3'h0};
    msk = (mem_o.size == SIZE_8) ? 32'h0000_00FF :
          (mem_o.size == SIZE_16) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    if (!mem.exists(key)) begin
      mem[key] = 32'h0000_0000;
    end
    if (mem_ack) begin
      if (mem_o.we) begin
        mem[key] = (mem[key] & ~(msk << sh)) | ((mem_o.wdata & msk) << sh);
      end
      mem_ack <= #1 1'b0;
      mem_rdata <= #1 ~mem_rdata;
      cnt = wait_cycles;
    end else if (mem_req && cnt == 2'h0) begin
      mem_rdata <= #1 (mem[key] >> sh) & msk;
      mem_ack <= #1 1'b1;
    end else begin
      if (mem_req) begin
        cnt = cnt - 2'h1;
      end
      mem_rdata <= #1 ~mem_rdata;
    end
  end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`define CHK(g, e) check_val(128'(g), 128'(e))
`define M vdtc_mem_model_i.mem
module tb;
  import vdtc_pkg::*;
  localparam logic [31:0] VB  = 32'h0000_1000;
  localparam logic [31:0] DA  = 32'h0000_2000;
  localparam logic [31:0] SRC = 32'h0000_3000;
  localparam logic [31:0] DST = 32'h0000_4000;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        module_start_control = 1'b1;
  logic        descriptor_address_mode = 1'b0;
  logic [31:0] vector_table_base = VB;
  logic        read_skip_enable = 1'b0;
  logic        act_req = 1'b0;
  logic [7:0]  act_vector = 8'h00;
  logic        source_activation_enable = 1'b1;
  logic [1:0]  wait_cycles = 2'h0;
  logic        act_ack, mem_req, mem_ack, cpu_irq, xfer_error, transfer_active;
  vdtc_mreq_s  mem_o;
  logic [31:0] mem_rdata, seed = 32'd41418, s, t;
  logic [7:0]  cpu_irq_vector, active_vector_number;
  logic [9:0]  exp_q [$];
  int          miscompares = 0;
  int          n_tests = 0;

  vdtc_core vdtc_core_i (.clock, .srst, .module_start_control, .descriptor_address_mode,
    .vector_table_base, .read_skip_enable, .act_req, .act_vector, .source_activation_enable,
    .act_ack, .mem_req, .mem_o, .mem_ack, .mem_rdata, .cpu_irq, .cpu_irq_vector,
    .xfer_error, .transfer_active, .active_vector_number);
  vdtc_mem_model vdtc_mem_model_i (.clock, .mem_req, .mem_o, .wait_cycles, .mem_ack,
    .mem_rdata);

  // clock and random bus wait
  always #4 clock = ~clock;
  always @(posedge clock) wait_cycles <= #1 2'(xs());

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check_val(input logic [127:0] g, input logic [127:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // vector entry, descriptor in ram, endpoints on chip
  task automatic wr_desc(input logic [7:0] v, input logic [31:0] da, input logic [7:0] ma,
                         input logic [7:0] mb, input logic [31:0] sa, input logic [31:0] dd,
                         input logic [15:0] ca, input logic [15:0] cb);
    `M[VB + {22'h0, v, 2'h0}] = da;
    if (descriptor_address_mode) begin
      `M[da] = {ma, sa[23:0]};
      `M[da + 4] = {mb, dd[23:0]};
      `M[da + 8] = {ca, cb};
    end else begin
      `M[da] = {ma, mb, 16'h0000};
      `M[da + 4] = sa;
      `M[da + 8] = dd;
      `M[da + 12] = {ca, cb};
    end
  endtask

  // request held until acked, then wait for idle
  task automatic activate(input logic [7:0] v, input logic en);
    int i;
    act_vector = v;
    source_activation_enable = en;
    act_req = 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (act_ack === 1'b1) break;
    end
    // a request that is never taken counts as a mismatch
    if (i == 50) miscompares++;
    #1 act_req = 1'b0;
    for (i = 0; i < 6000 && transfer_active === 1'b1; i++) @(posedge clock);
    // a transfer that never ends counts as a mismatch
    if (transfer_active !== 1'b0) miscompares++;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // each irq or error pulse matched to the oldest note
  always @(negedge clock) begin
    if (!srst && (cpu_irq === 1'b1 || xfer_error === 1'b1)) begin
      if (exp_q.size() == 0) `CHK({xfer_error, cpu_irq, cpu_irq_vector}, 10'h000);
      else `CHK({xfer_error, cpu_irq, cpu_irq ? cpu_irq_vector : 8'h00}, exp_q.pop_front());
    end
  end

  // watchdog
  initial begin
    #400000;
    miscompares++;
    report_and_stop();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    #1 srst = 1'b0;
    `CHK({transfer_active, active_vector_number, mem_req}, 10'h000);
    s = xs();
    t = xs();
    `M[SRC] = s;
    `M[SRC + 4] = t;
    wr_desc(8'h21, DA, {MODE_NORMAL, SIZE_32, AM_INC, 2'h0}, {4'h0, AM_INC, 2'h0},
            SRC, DST, 16'h0002, 16'h0000);
    activate(8'h21, 1'b1);
    `CHK(active_vector_number, 8'h21);
    `CHK(`M[DST], s);
    `CHK({`M[DA + 4], `M[DA + 8], `M[DA + 12]}, {SRC + 4, DST + 4, 32'h0001_0000});
    exp_q.push_back({2'b01, 8'h21});
    activate(8'h21, 1'b1);
    `CHK(`M[DST + 4], t);
    $display("test normal done");
    // block of 256 bytes, destination side restored
    for (int k = 0; k < 64; k++) `M[SRC + 4 * k] = xs();
    wr_desc(8'h22, DA, {MODE_BLOCK, SIZE_8, AM_INC, 2'h0}, {4'h0, AM_INC, 2'h0},
            SRC, DST, 16'h0000, 16'h0001);
    exp_q.push_back({2'b01, 8'h22});
    activate(8'h22, 1'b1);
    `CHK({`M[DST], `M[DST + 252]}, {`M[SRC], `M[SRC + 252]});
    `CHK({`M[DA + 4], `M[DA + 8]}, {SRC + 256, DST});
    // block of three halfwords, irq after every unit
    wr_desc(8'h30, DA, {MODE_BLOCK, SIZE_16, AM_INC, 2'h0}, {4'h3, AM_INC, 2'h0},
            SRC, DST, 16'h0303, 16'h0002);
    repeat (3) exp_q.push_back({2'b01, 8'h30});
    `M[DST + 4] = 32'h0000_0000;
    activate(8'h30, 1'b1);
    `CHK(`M[DST + 4] & 32'hFFFF, `M[SRC + 4] & 32'hFFFF);
    `CHK({`M[DA + 4], `M[DA + 8]}, {SRC, DST + 6});
    $display("test block done");
    // repeat mode in short layout reloads and restores
    descriptor_address_mode = 1'b1;
    wr_desc(8'h31, DA + 32'h100, {MODE_REPEAT, SIZE_16, AM_INC, 2'h0}, {4'h0, AM_INC, 2'h0},
            SRC, DST, 16'h0202, 16'h0000);
    repeat (2) activate(8'h31, 1'b1);
    `CHK(`M[DA + 32'h108], 32'h0202_0000);
    `CHK(`M[DA + 32'h104], {4'h0, AM_INC, 2'h0, DST[23:0]});
    `CHK(`M[DA + 32'h100][23:0], SRC[23:0] + 24'h4);
    descriptor_address_mode = 1'b0;
    $display("test repeat done");
    // chain into a second descriptor that skips write-back
    `M[DST + 8] = 32'h0000_0000;
    wr_desc(8'h44, DA + 16, {MODE_NORMAL, SIZE_32, AM_INC, 2'h0}, {4'h0, AM_INC, 2'h2},
            SRC + 8, DST + 8, 16'h0005, 16'h0000);
    wr_desc(8'h44, DA, {MODE_NORMAL, SIZE_32, AM_INC, 2'h0}, {4'h8, AM_INC, 2'h0},
            SRC, DST, 16'h0005, 16'h0000);
    activate(8'h44, 1'b1);
    `CHK({`M[DST + 8], `M[DA + 4], `M[DA + 20]}, {`M[SRC + 8], SRC + 4, SRC + 8});
    $display("test chain done");
    // read skip reuses the held descriptor although the vector entry moved
    read_skip_enable = 1'b1;
    `M[DST + 132] = 32'h0000_0000;
    wr_desc(8'h70, DA, {MODE_NORMAL, SIZE_32, AM_INC, 2'h0}, {4'h0, AM_INC, 2'h0},
            SRC, DST + 128, 16'h0003, 16'h0000);
    activate(8'h70, 1'b1);
    `M[VB + 32'h1C0] = DA + 32'h200;
    activate(8'h70, 1'b1);
    read_skip_enable = 1'b0;
    `CHK(`M[DST + 132], `M[SRC + 4]);
    $display("test skip done");
    // disabled source and stopped module only forward the request
    `M[DST + 64] = 32'h0000_0000;
    wr_desc(8'h50, DA, {MODE_NORMAL, SIZE_32, AM_INC, 2'h0}, {4'h0, AM_INC, 2'h0},
            SRC, DST + 64, 16'h0005, 16'h0000);
    exp_q.push_back({2'b01, 8'h50});
    activate(8'h50, 1'b0);
    module_start_control = 1'b0;
    exp_q.push_back({2'b01, 8'h50});
    activate(8'h50, 1'b1);
    module_start_control = 1'b1;
    `CHK(`M[DST + 64], 32'h0000_0000);
    $display("test forward done");
    // register spaces of both controllers refused, no write-back
    for (int k = 0; k < 2; k++) begin
      wr_desc(8'h60, DA, {MODE_NORMAL, SIZE_32, AM_INC, 2'h0}, {4'h0, AM_INC, 2'h0},
              k ? SELF_REG_LO : SRC, k ? DST : DMA_CONTROLLER_REG_HI - 3, 16'h0005, 16'h0000);
      exp_q.push_back(10'h200);
      activate(8'h60, 1'b1);
      `CHK(`M[DA + 4], k ? SELF_REG_LO : SRC);
    end
    $display("test forbidden done");
    `CHK(exp_q.size(), 0);
    report_and_stop();
  end
endmodule
